// ### pss_contact_model.sv
// Contact input terminals outside the drive.
// Assumes the bench asks for levels; contacts settle off the clock edge.
`timescale 1ns/1ps
module pss_contact_model
    import pss_pkg::*;
(
    // Requested and driven levels
    input wire logic [PSS_NUM_TERMS-1:0] want_i,
    output logic [PSS_NUM_TERMS-1:0] term_o
);
    // Contacts close with no relation to the drive clock
    initial term_o = '0;
    always @(want_i) begin
        term_o <= #7 want_i;
    end
endmodule : pss_contact_model

// ### pss_pkg.sv
// Constants, field layouts and carrier types for the preset speed selector.
// Assumes a single 40 MHz system clock and an active-low asynchronous reset.
// Notes on behaviour
// - A lone high, middle or low select drives out the high, middle or low speed preset.
// - After reset the high, middle and low presets hold 50 Hz, 30 Hz and 10 Hz.
// - Every preset takes 0 to 400 Hz, and the extended presets also take the not-selected code.
// - Speeds 4 to 15 each have a preset chosen by their own mix of high, middle, low and extension.
// - Extended presets reset to 9999, and a preset holding 9999 counts as not selected.
// - With two or three of high, middle and low on and that combination's preset at 9999, the lowest-ranked active select wins.
// - A terminal whose assignment code is 8 carries the extension select.
// - Low, middle and high sit on their own terminals by default, and codes 0, 1, 2 move them.
// - With speed 8 at 9999 and only the extension select on, the low preset is used.
// - Presets stay writable while running, in every mode, whatever the write protection.
// - Command sources rank jog, then presets, then current input, then voltage input.
// - Preset selection acts only with the operation mode at 3 or 4.
// - A nonzero remote function setting disables preset selection entirely.
package pss_pkg;

    // Frequencies are carried in 0.1 Hz steps
    localparam int PSS_FREQ_W = 16;
    localparam int PSS_NUM_PRESETS = 15;
    localparam int PSS_NUM_TERMS = 7;
    localparam int PSS_SYNC_STAGES = 2;

    localparam logic [15:0] PSS_FREQ_MAX = 16'h0fa0;      // 400.0 Hz
    localparam logic [15:0] PSS_NOT_SELECTED = 16'h270f;  // Code 9999
    localparam logic [15:0] PSS_RST_HIGH = 16'h01f4;      // 50.0 Hz
    localparam logic [15:0] PSS_RST_MID = 16'h012c;       // 30.0 Hz
    localparam logic [15:0] PSS_RST_LOW = 16'h0064;       // 10.0 Hz

    // Preset table indices: speed n lives at index n-1
    localparam logic [3:0] PSS_IDX_HIGH = 4'h0;
    localparam logic [3:0] PSS_IDX_MID = 4'h1;
    localparam logic [3:0] PSS_IDX_LOW = 4'h2;
    localparam logic [3:0] PSS_IDX_SPEED8 = 4'h7;

    // Terminal function-assignment codes
    localparam logic [7:0] PSS_FN_LOW = 8'h00;
    localparam logic [7:0] PSS_FN_MID = 8'h01;
    localparam logic [7:0] PSS_FN_HIGH = 8'h02;
    localparam logic [7:0] PSS_FN_EXT = 8'h08;
    localparam logic [7:0] PSS_FN_NONE = 8'hff;

    // Operation modes that allow preset selection, then setting reset values and the protection lock code
    localparam logic [7:0] PSS_MODE_EXT = 8'h03;
    localparam logic [7:0] PSS_MODE_COMB = 8'h04;
    localparam logic [7:0] PSS_RST_MODE = 8'h00;
    localparam logic [7:0] PSS_RST_REMOTE = 8'h00;
    localparam logic [7:0] PSS_RST_PROTECT = 8'h00;
    localparam logic [7:0] PSS_PROTECT_LOCK = 8'h01;

    // Register map, word addresses on the plain port
    localparam logic [7:0] PSS_ADDR_PRESET0 = 8'h00;
    localparam logic [7:0] PSS_ADDR_TERM0 = 8'h10;
    localparam logic [7:0] PSS_ADDR_MODE = 8'h18;
    localparam logic [7:0] PSS_ADDR_REMOTE = 8'h19;
    localparam logic [7:0] PSS_ADDR_PROTECT = 8'h1a;
    localparam logic [7:0] PSS_ADDR_STATUS = 8'h1c;

    // Command source encodings
    typedef enum logic [1:0] {
        PSS_SRC_JOG = 2'b00,
        PSS_SRC_PRESET = 2'b01,
        PSS_SRC_CURRENT = 2'b10,
        PSS_SRC_VOLTAGE = 2'b11
    } pss_src_e;

    // Resolved select signals
    typedef struct packed {
        logic ext;
        logic high;
        logic mid;
        logic low;
    } pss_sel_s;

    // Frequency command handed to the generator
    typedef struct packed {
        logic [15:0] freq;
        pss_src_e src;
        logic [3:0] speed;
    } pss_cmd_s;

endpackage : pss_pkg

// ### pss_selector.sv
// Preset speed selector: preset table, terminal mapping and command priority.
// Assumes terminal inputs are raw pins; jog and analog commands come from logic on sys_clk_i.
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module pss_selector
    import pss_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    // Contact input terminals, asynchronous
    input wire logic [PSS_NUM_TERMS-1:0] term_i,
    // Jog and lower-priority commands
    input wire logic jog_active_i,
    input wire logic [15:0] jog_freq_i,
    input wire logic current_valid_i,
    input wire logic [15:0] current_freq_i,
    input wire logic [15:0] voltage_freq_i,
    // Command to the frequency generator
    output logic [15:0] freq_cmd_o,
    output logic [1:0] freq_src_o,
    output logic [3:0] speed_o,
    output logic preset_active_o
);

    logic [PSS_NUM_TERMS-1:0] term_sync;
    logic [15:0] preset_q [PSS_NUM_PRESETS];
    logic [15:0] preset_d [PSS_NUM_PRESETS];
    logic [7:0] assign_q [PSS_NUM_TERMS];
    logic [7:0] assign_d [PSS_NUM_TERMS];
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [7:0] remote_q;
    logic [7:0] remote_d;
    logic [7:0] protect_q;
    logic [7:0] protect_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    pss_cmd_s cmd_q;
    pss_cmd_s cmd_d;
    logic preset_act_q;
    logic preset_act_d;
    pss_sel_s sel;
    logic [PSS_NUM_TERMS-1:0] hit_low;
    logic [PSS_NUM_TERMS-1:0] hit_mid;
    logic [PSS_NUM_TERMS-1:0] hit_high;
    logic [PSS_NUM_TERMS-1:0] hit_ext;
    logic [3:0] pick_idx;
    logic pick_ok;
    logic preset_allowed;

    // Pins are asynchronous, so every terminal passes two flip-flops first
    pss_sync #(
        .WIDTH(PSS_NUM_TERMS)
    ) u_term_sync (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .async_i(term_i),
        .sync_o(term_sync)
    );

    // Each terminal contributes to the function its assignment names
    for (genvar t = 0; t < PSS_NUM_TERMS; t++) begin : g_term
        assign hit_low[t] = term_sync[t] && (assign_q[t] == PSS_FN_LOW);
        assign hit_mid[t] = term_sync[t] && (assign_q[t] == PSS_FN_MID);
        assign hit_high[t] = term_sync[t] && (assign_q[t] == PSS_FN_HIGH);
        assign hit_ext[t] = term_sync[t] && (assign_q[t] == PSS_FN_EXT);
    end

    // Several terminals may share one function; any of them turns it on
    always_comb begin
        sel.low = |hit_low;
        sel.mid = |hit_mid;
        sel.high = |hit_high;
        sel.ext = |hit_ext;
    end

    // Choose a preset index from the select pattern
    always_comb begin
        logic [3:0] prio_idx;
        logic [3:0] combo_idx;
        logic multi;
        prio_idx = PSS_IDX_HIGH;
        combo_idx = PSS_IDX_HIGH;
        multi = 1'b0;
        pick_idx = PSS_IDX_HIGH;
        pick_ok = 1'b0;
        // Lowest-ranked active select wins among the three
        if (sel.low) begin
            prio_idx = PSS_IDX_LOW;
        end else if (sel.mid) begin
            prio_idx = PSS_IDX_MID;
        end else begin
            prio_idx = PSS_IDX_HIGH;
        end
        // Map the combination to speeds 4 to 15
        unique case ({sel.ext, sel.high, sel.mid, sel.low})
            4'b0011: combo_idx = 4'h3;
            4'b0101: combo_idx = 4'h4;
            4'b0110: combo_idx = 4'h5;
            4'b0111: combo_idx = 4'h6;
            4'b1000: combo_idx = 4'h7;
            4'b1001: combo_idx = 4'h8;
            4'b1010: combo_idx = 4'h9;
            4'b1011: combo_idx = 4'ha;
            4'b1100: combo_idx = 4'hb;
            4'b1101: combo_idx = 4'hc;
            4'b1110: combo_idx = 4'hd;
            4'b1111: combo_idx = 4'he;
            default: combo_idx = PSS_IDX_HIGH;
        endcase
        multi = sel.ext || ((sel.high && sel.mid) || (sel.high && sel.low) || (sel.mid && sel.low));
        if (!sel.ext && !sel.high && !sel.mid && !sel.low) begin
            pick_ok = 1'b0;
        end else if (!multi) begin
            pick_idx = prio_idx;
            pick_ok = 1'b1;
        end else if (preset_q[combo_idx] != PSS_NOT_SELECTED) begin
            pick_idx = combo_idx;
            pick_ok = 1'b1;
        end else if (sel.high || sel.mid || sel.low) begin
            // Extended speed not set up: fall back to the plain three-speed choice
            pick_idx = prio_idx;
            pick_ok = 1'b1;
        end else begin
            pick_idx = PSS_IDX_LOW;
            pick_ok = 1'b1;
        end
    end

    // Presets count only in external or combined mode with remote setting off
    assign preset_allowed = ((mode_q == PSS_MODE_EXT) || (mode_q == PSS_MODE_COMB))
        && (remote_q == PSS_RST_REMOTE);

    // Rank the command sources
    always_comb begin
        cmd_d.freq = voltage_freq_i;
        cmd_d.src = PSS_SRC_VOLTAGE;
        cmd_d.speed = 4'h0;
        preset_act_d = 1'b0;
        if (jog_active_i) begin
            cmd_d.freq = jog_freq_i;
            cmd_d.src = PSS_SRC_JOG;
        end else if (preset_allowed && pick_ok) begin
            cmd_d.freq = preset_q[pick_idx];
            cmd_d.src = PSS_SRC_PRESET;
            cmd_d.speed = 4'(pick_idx + 4'h1);
            preset_act_d = 1'b1;
        end else if (current_valid_i) begin
            cmd_d.freq = current_freq_i;
            cmd_d.src = PSS_SRC_CURRENT;
        end else begin
            cmd_d.freq = voltage_freq_i;
            cmd_d.src = PSS_SRC_VOLTAGE;
        end
    end

    // Register writes; presets ignore protection and run state entirely
    always_comb begin
        logic unlocked;
        logic [7:0] rel;
        unlocked = (protect_q != PSS_PROTECT_LOCK);
        rel = 8'(reg_addr_i - PSS_ADDR_TERM0);
        for (int i = 0; i < PSS_NUM_PRESETS; i++) begin
            preset_d[i] = preset_q[i];
        end
        for (int t = 0; t < PSS_NUM_TERMS; t++) begin
            assign_d[t] = assign_q[t];
        end
        mode_d = mode_q;
        remote_d = remote_q;
        protect_d = protect_q;
        if (reg_wr_i) begin
            if (reg_addr_i < 8'(PSS_NUM_PRESETS)) begin
                // Out-of-range values are dropped; 9999 only for speeds 4 to 15
                if ((reg_wdata_i <= PSS_FREQ_MAX)
                    || ((reg_addr_i[3:0] > PSS_IDX_LOW) && (reg_wdata_i == PSS_NOT_SELECTED))) begin
                    preset_d[reg_addr_i[3:0]] = reg_wdata_i;
                end
            end else if ((reg_addr_i >= PSS_ADDR_TERM0) && (rel < 8'(PSS_NUM_TERMS))) begin
                if (unlocked) begin
                    assign_d[rel[2:0]] = reg_wdata_i[7:0];
                end
            end else if (reg_addr_i == PSS_ADDR_MODE) begin
                if (unlocked) begin
                    mode_d = reg_wdata_i[7:0];
                end
            end else if (reg_addr_i == PSS_ADDR_REMOTE) begin
                if (unlocked) begin
                    remote_d = reg_wdata_i[7:0];
                end
            end else if (reg_addr_i == PSS_ADDR_PROTECT) begin
                protect_d = reg_wdata_i[7:0];
            end
        end
    end

    // Read mux; data stand for exactly the cycle after the strobe
    always_comb begin
        logic [7:0] rel;
        rel = 8'(reg_addr_i - PSS_ADDR_TERM0);
        rdata_d = 16'h0000;
        if (reg_rd_i) begin
            if (reg_addr_i < 8'(PSS_NUM_PRESETS)) begin
                rdata_d = preset_q[reg_addr_i[3:0]];
            end else if ((reg_addr_i >= PSS_ADDR_TERM0) && (rel < 8'(PSS_NUM_TERMS))) begin
                rdata_d = {8'h00, assign_q[rel[2:0]]};
            end else if (reg_addr_i == PSS_ADDR_MODE) begin
                rdata_d = {8'h00, mode_q};
            end else if (reg_addr_i == PSS_ADDR_REMOTE) begin
                rdata_d = {8'h00, remote_q};
            end else if (reg_addr_i == PSS_ADDR_PROTECT) begin
                rdata_d = {8'h00, protect_q};
            end else if (reg_addr_i == PSS_ADDR_STATUS) begin
                // Live view of the resolved selects and the chosen source
                rdata_d = {5'h00, preset_act_q, cmd_q.src, cmd_q.speed,
                    sel.ext, sel.high, sel.mid, sel.low};
            end
        end
    end

    // Preset table with its reset values
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < PSS_NUM_PRESETS; i++) begin
                preset_q[i] <= PSS_NOT_SELECTED;
            end
            preset_q[PSS_IDX_HIGH] <= PSS_RST_HIGH;
            preset_q[PSS_IDX_MID] <= PSS_RST_MID;
            preset_q[PSS_IDX_LOW] <= PSS_RST_LOW;
        end else begin
            for (int i = 0; i < PSS_NUM_PRESETS; i++) begin
                preset_q[i] <= preset_d[i];
            end
        end
    end

    // Terminal assignments: low, middle, high on terminals 0, 1, 2
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int t = 0; t < PSS_NUM_TERMS; t++) begin
                assign_q[t] <= PSS_FN_NONE;
            end
            assign_q[0] <= PSS_FN_LOW;
            assign_q[1] <= PSS_FN_MID;
            assign_q[2] <= PSS_FN_HIGH;
        end else begin
            for (int t = 0; t < PSS_NUM_TERMS; t++) begin
                assign_q[t] <= assign_d[t];
            end
        end
    end

    // Settings, command and read data
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q <= PSS_RST_MODE;
            remote_q <= PSS_RST_REMOTE;
            protect_q <= PSS_RST_PROTECT;
            rdata_q <= 16'h0000;
            cmd_q <= '0;
            preset_act_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            remote_q <= remote_d;
            protect_q <= protect_d;
            rdata_q <= rdata_d;
            cmd_q <= cmd_d;
            preset_act_q <= preset_act_d;
        end
    end

    // Outputs come straight from flip-flops
    assign reg_rdata_o = rdata_q;
    assign freq_cmd_o = cmd_q.freq;
    assign freq_src_o = cmd_q.src;
    assign speed_o = cmd_q.speed;
    assign preset_active_o = preset_act_q;

endmodule : pss_selector

// ### pss_selector_assertions.sv
// Checker for the selector's command and register outputs.
// Assumes it is bound to pss_selector and sees its ports only.
`timescale 1ns/1ps
module pss_selector_assertions
    import pss_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    // Terminals and commands
    input wire logic [PSS_NUM_TERMS-1:0] term_i,
    input wire logic jog_active_i,
    input wire logic [15:0] jog_freq_i,
    input wire logic current_valid_i,
    input wire logic [15:0] current_freq_i,
    input wire logic [15:0] voltage_freq_i,
    input wire logic [15:0] freq_cmd_o,
    input wire logic [1:0] freq_src_o,
    input wire logic [3:0] speed_o,
    input wire logic preset_active_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Three quiet samples cover the synchroniser and the output stage
    sequence s_quiet;
        (!jog_active_i && term_i == '0) [*3];
    endsequence
    property p_rd_idle;
        !reg_rd_i |=> reg_rdata_o == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_jog;
        jog_active_i |=> freq_src_o == 2'h0 && freq_cmd_o == $past(jog_freq_i);
    endproperty
    a_jog: assert property (p_jog) else $error("jog not first");
    property p_volt;
        s_quiet ##0 !current_valid_i |=> freq_src_o == 2'h3 && freq_cmd_o == $past(voltage_freq_i);
    endproperty
    a_volt: assert property (p_volt) else $error("voltage command not passed");
    property p_curr;
        s_quiet ##0 current_valid_i |=> freq_src_o == 2'h2 && freq_cmd_o == $past(current_freq_i);
    endproperty
    a_curr: assert property (p_curr) else $error("current command not passed");
    property p_active;
        preset_active_o |-> freq_src_o == 2'h1 && speed_o != 4'h0;
    endproperty
    a_active: assert property (p_active) else $error("preset flag without speed");
    property p_idle_speed;
        !preset_active_o |-> speed_o == 4'h0;
    endproperty
    a_idle_speed: assert property (p_idle_speed) else $error("speed without preset");
    property p_range;
        preset_active_o |-> freq_cmd_o <= PSS_FREQ_MAX;
    endproperty
    a_range: assert property (p_range) else $error("preset frequency out of range");
    property p_rise;
        $rose(preset_active_o) |-> $past(term_i, 3) != '0;
    endproperty
    a_rise: assert property (p_rise) else $error("preset without a select");
    c_preset: cover property (preset_active_o && speed_o > 4'h3);
    c_jog: cover property ($past(jog_active_i) && freq_src_o == 2'h0);
    c_curr: cover property (freq_src_o == 2'h2);
endmodule : pss_selector_assertions

bind pss_selector pss_selector_assertions u_chk (.*);

// ### pss_sync.sv
// Two-stage synchroniser for the contact input terminals.
// Assumes inputs are asynchronous levels; the first stage feeds only the second.
`timescale 1ns/1ps
module pss_sync
    import pss_pkg::*;
#(
    parameter int WIDTH = PSS_NUM_TERMS
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    // Raw and synchronised levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    // Next values of both stages
    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    // Stage registers, cleared at reset
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;

endmodule : pss_sync

// ### tb_pss_selector.sv
// Self-checking bench for the preset speed selector.
// Assumes a 40 MHz clock and the contact model in front of the terminals.
`timescale 1ns/1ps
module tb_pss_selector;
    import pss_pkg::*;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic jog = 1'b0;
    logic cv = 1'b0;
    logic [15:0] jf = 16'h0000;
    logic [15:0] cf = 16'h0000;
    logic [15:0] vf = 16'h0000;
    logic [6:0] want = 7'h00;
    logic [6:0] term;
    logic [15:0] rdata;
    logic [15:0] freq;
    logic [1:0] src;
    logic [3:0] speed;
    logic active;
    int n_errors = 0;
    int n_checks = 0;
    integer seed = 32'hf90fc915;
    // Shadow settings, updated by the same rules as the device
    logic [15:0] pre [15];
    logic [7:0] asg [7];
    logic [7:0] mode;
    logic [7:0] remote;
    logic [7:0] prot;
    logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h02, 8'h08, 8'hff};

    always #12.5 sys_clk_i = ~sys_clk_i;

    pss_selector dut_u (.sys_clk_i, .arst_n_i, .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .term_i(term),
        .jog_active_i(jog), .jog_freq_i(jf), .current_valid_i(cv), .current_freq_i(cf),
        .voltage_freq_i(vf), .freq_cmd_o(freq), .freq_src_o(src), .speed_o(speed),
        .preset_active_o(active));
    pss_contact_model contact_u (.want_i(want), .term_o(term));

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic [15:0] exp_reg(logic [7:0] a);
        if (a < 8'h0f) return pre[a[3:0]];
        if (a >= 8'h10 && a <= 8'h16) return {8'h00, asg[a[2:0]]};
        if (a == PSS_ADDR_MODE) return {8'h00, mode};
        if (a == PSS_ADDR_REMOTE) return {8'h00, remote};
        if (a == PSS_ADDR_PROTECT) return {8'h00, prot};
        return 16'h0000;
    endfunction : exp_reg

    // Resolved {ext, high, mid, low} for the given terminal levels
    function automatic logic [3:0] exp_sel(logic [6:0] t);
        logic [3:0] s;
        s = 4'h0;
        for (int i = 0; i < 7; i++) begin
            s[0] |= t[i] && asg[i] == PSS_FN_LOW;
            s[1] |= t[i] && asg[i] == PSS_FN_MID;
            s[2] |= t[i] && asg[i] == PSS_FN_HIGH;
            s[3] |= t[i] && asg[i] == PSS_FN_EXT;
        end
        return s;
    endfunction : exp_sel

    // Expected {freq, src, speed, active} for the given terminal levels
    function automatic logic [22:0] exp_cmd(logic [6:0] t);
        logic h, m, l, x;
        logic [2:0] v;
        logic [3:0] c, sp;
        {x, h, m, l} = exp_sel(t);
        v = {h, m, l};
        c = x ? {1'b1, v} : (v == 3'h3) ? 4'h4 : (v > 3'h4) ? {1'b0, v} : 4'h0;
        // A combination at 9999 falls back to the lowest active select
        sp = (c != 4'h0 && pre[c - 4'h1] != PSS_NOT_SELECTED) ? c
            : (l || (x && v == 3'h0)) ? 4'h3 : m ? 4'h2 : h ? 4'h1 : 4'h0;
        if (jog) return {jf, 7'h00};
        if (sp != 4'h0 && (mode == PSS_MODE_EXT || mode == PSS_MODE_COMB) && remote == 8'h00)
            return {pre[sp - 4'h1], 2'h1, sp, 1'b1};
        if (cv) return {cf, 7'h40};
        return {vf, 7'h60};
    endfunction : exp_cmd

    task automatic wr_reg(logic [7:0] a, logic [15:0] d);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
        // Presets ignore protection; bad values leave the old one in place
        if (a < 8'h0f) begin
            if (d <= PSS_FREQ_MAX || (d == PSS_NOT_SELECTED && a > 8'h02)) pre[a[3:0]] = d;
        end else if (prot != PSS_PROTECT_LOCK || a == PSS_ADDR_PROTECT) begin
            if (a >= 8'h10 && a <= 8'h16) asg[a[2:0]] = d[7:0];
            if (a == PSS_ADDR_MODE) mode = d[7:0];
            if (a == PSS_ADDR_REMOTE) remote = d[7:0];
            if (a == PSS_ADDR_PROTECT) prot = d[7:0];
        end
    endtask : wr_reg

    task automatic rd_all();
        for (int a = 0; a < 28; a++) begin
            @(posedge sys_clk_i);
            addr <= 8'(a);
            rd <= 1'b1;
            @(posedge sys_clk_i);
            rd <= 1'b0;
            #1 chk("register", rdata, exp_reg(8'(a)));
        end
    endtask : rd_all

    // Terminals go through the contacts; random commands ride along
    task automatic drive(logic [6:0] t, logic j, logic c);
        logic [22:0] e;
        @(posedge sys_clk_i);
        want <= t;
        jog <= j;
        cv <= c;
        jf <= 16'($random(seed));
        cf <= 16'($random(seed));
        vf <= 16'($random(seed));
        repeat (5) @(posedge sys_clk_i);
        #1 chk("command", {freq, src, speed, active}, exp_cmd(t));
        // Status shows the registered source beside the live selects
        e = exp_cmd(t);
        @(posedge sys_clk_i);
        addr <= PSS_ADDR_STATUS;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1 chk("status", rdata, {5'h00, e[0], e[6:1], exp_sel(t)});
    endtask : drive

    task automatic sweep(string s);
        for (int i = 0; i < 16; i++) drive(7'(i), 1'b0, i[0]);
        $display("test %s done", s);
    endtask : sweep

    initial begin
        pre = '{default: PSS_NOT_SELECTED};
        pre[0] = PSS_RST_HIGH;
        pre[1] = PSS_RST_MID;
        pre[2] = PSS_RST_LOW;
        asg = '{PSS_FN_LOW, PSS_FN_MID, PSS_FN_HIGH, 8'hff, 8'hff, 8'hff, 8'hff};
        mode = PSS_RST_MODE;
        remote = PSS_RST_REMOTE;
        prot = PSS_RST_PROTECT;
        repeat (4) @(posedge sys_clk_i);
        arst_n_i <= 1'b1;
        rd_all();
        $display("test reset values done");
        sweep("mode off");
        wr_reg(PSS_ADDR_MODE, 16'h0003);
        wr_reg(8'h13, 16'h0008);
        sweep("fallback table");
        // Protection locks the mode but never the presets
        wr_reg(PSS_ADDR_PROTECT, 16'h0001);
        wr_reg(PSS_ADDR_MODE, 16'h0000);
        for (int i = 3; i < 15; i++) wr_reg(8'(i), 16'($random(seed)) % 16'h0fa1);
        wr_reg(8'h07, PSS_NOT_SELECTED);
        wr_reg(8'h00, 16'h0fa1);
        wr_reg(8'h02, PSS_NOT_SELECTED);
        wr_reg(8'h01, PSS_FREQ_MAX);
        wr_reg(PSS_ADDR_PROTECT, 16'h0000);
        wr_reg(PSS_ADDR_MODE, 16'h0004);
        rd_all();
        sweep("full table");
        wr_reg(PSS_ADDR_REMOTE, 16'h0001);
        sweep("remote");
        wr_reg(PSS_ADDR_REMOTE, 16'h0000);
        for (int n = 0; n < 300; n++) begin
            if (n % 10 == 0) wr_reg(8'h10 + 8'($unsigned($random(seed)) % 7),
                {8'h00, codes[$unsigned($random(seed)) % 5]});
            if (n % 7 == 0) wr_reg(8'($unsigned($random(seed)) % 15), 16'($random(seed)) & 16'h1fff);
            drive(7'($random(seed)), ($random(seed) & 3) == 0, 1'($random(seed)));
        end
        rd_all();
        $display("test random done");
        report_and_stop();
    end

    // Hang guard, far beyond the few thousand cycles the tests need
    initial begin
        #500000;
        n_errors++;
        report_and_stop();
    end
endmodule : tb_pss_selector
